// ---- include/coe_defs.vh ----
// constants for the emergency, heartbeat and identity dictionary objects
// assumes a 16-bit index and 8-bit sub-index access port in front of it
// Operation
// - bit 31 invalid flag, bit 30 zero
// - bit 29 selects extended identifier format
// - bits 28..11 zero in standard format
// - standard-only device rejects bit 29 set
// - identifier bits locked while object valid
// - identifier resets to 0x080 plus node
// - inhibit time writable, 100us units, zero
// - heartbeat period 16 bit, 1ms, zero
// - zero heartbeat period disables heartbeat
// - identity count reads 4, read only
// - sub-index 1 read-only maker code
// - revision major high, minor low half
// - major tracks protocol, minor tracks builds
// - sub-index 2 read-only product code
// - sub-index 4 read-only unit serial
`ifndef COE_DEFS_VH
`define COE_DEFS_VH

`define COE_IDX_EMERGENCY_MESSAGE_ID    16'h1014
`define COE_IDX_EMERGENCY_MESSAGE_INH   16'h1015
`define COE_IDX_HB_PERIOD  16'h1017
`define COE_IDX_IDENTITY   16'h1018

`define COE_SUB_COUNT      8'h00
`define COE_SUB_MAKER      8'h01
`define COE_SUB_PRODUCT    8'h02
`define COE_SUB_REVISION   8'h03
`define COE_SUB_SERIAL     8'h04
`define COE_IDENT_COUNT    32'h0000_0004

`define COE_EMERGENCY_MESSAGE_INVALID_BIT 31
`define COE_EMERGENCY_MESSAGE_RSVD_BIT    30
`define COE_EMERGENCY_MESSAGE_EXT_BIT     29
`define COE_EMERGENCY_MESSAGE_BASE        32'h0000_0080

`define COE_INH_RESET      16'h0000
`define COE_HB_RESET       16'h0000

`define COE_ABORT_NONE     32'h0000_0000
`define COE_ABORT_VALUE    32'h0609_0030
`define COE_ABORT_RDONLY   32'h0601_0002
`define COE_ABORT_NOOBJ    32'h0602_0000
`define COE_ABORT_NOSUB    32'h0609_0011

// timing: 100 us and 1 ms ticks at 50 MHz
`define COE_CLK_MHZ        50
`define COE_INH_UNIT_US    100
`define COE_HB_UNIT_US     1000
`define COE_INH_UNIT_CYC   (`COE_INH_UNIT_US * `COE_CLK_MHZ)
`define COE_HB_UNIT_CYC    (`COE_HB_UNIT_US * `COE_CLK_MHZ)

`endif

// ---- src/coe_tick.v ----
// one-cycle enable pulse divider
// assumes a single free-running clock
`timescale 1ns/1ps
`default_nettype none
module coe_tick #(
  parameter integer DIV = 50000
) (
  input  wire i_clk,
  input  wire i_rst_b,
  output reg  o_tick
);
  reg [31:0] cnt_r;

  // count up and pulse once per DIV cycles
  always @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      cnt_r  <= 32'h0000_0000;
      o_tick <= 1'b0;
    end
    else if (cnt_r == DIV - 1)
    begin
      cnt_r  <= 32'h0000_0000;
      o_tick <= 1'b1;
    end
    else
    begin
      cnt_r  <= cnt_r + 32'h0000_0001;
      o_tick <= 1'b0;
    end
  end
endmodule // coe_tick
`default_nettype wire

// ---- src/coe_period.v ----
// period timer: pulses every PERIOD ticks, silent while PERIOD is zero
// assumes i_tick is a one-cycle enable at the unit rate
`timescale 1ns/1ps
`default_nettype none
module coe_period (
  input  wire        i_clk,
  input  wire        i_rst_b,
  input  wire        i_tick,
  input  wire [15:0] i_period,
  output reg         o_fire
);
  reg [15:0] cnt_r;

  // restart count whenever the period is zero so a new value starts fresh
  always @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      cnt_r  <= 16'h0000;
      o_fire <= 1'b0;
    end
    else if (i_period == 16'h0000)
    begin
      cnt_r  <= 16'h0000;
      o_fire <= 1'b0;
    end
    else if (i_tick)
    begin
      if (cnt_r + 16'h0001 >= i_period)
      begin
        cnt_r  <= 16'h0000;
        o_fire <= 1'b1;
      end
      else
      begin
        cnt_r  <= cnt_r + 16'h0001;
        o_fire <= 1'b0;
      end
    end
    else
      o_fire <= 1'b0;
  end
endmodule // coe_period
`default_nettype wire

// ---- src/coe_objects.v ----
// dictionary objects: emergency identifier, inhibit time, heartbeat
// period and identity record, with abort answers on bad accesses
// assumes the transfer layer presents one access per request pulse
`timescale 1ns/1ps
`default_nettype none
`include "coe_defs.vh"
module coe_objects #(
  parameter        EXT_SUPPORT = 0,
  parameter [31:0] MAKER_CODE  = 32'h0000_0001, // arbitrary value
  parameter [31:0] PRODUCT     = 32'h0000_0001, // arbitrary value
  parameter [15:0] REV_MAJOR   = 16'h0001,      // arbitrary value
  parameter [15:0] REV_MINOR   = 16'h0001,      // arbitrary value
  parameter [31:0] SERIAL      = 32'h0000_0001, // arbitrary value
  parameter integer INH_CYC    = `COE_INH_UNIT_CYC,
  parameter integer HB_CYC     = `COE_HB_UNIT_CYC
) (
  input  wire        i_clk,
  input  wire        i_rst_b,
  input  wire [6:0]  i_node_id,
  input  wire        i_req,
  input  wire        i_wr,
  input  wire [15:0] i_index,
  input  wire [7:0]  i_sub,
  input  wire [31:0] i_wdata,
  output reg         o_ack,
  output reg  [31:0] o_rdata,
  output reg  [31:0] o_abort,
  output reg  [31:0] o_emergency_message_id,
  output wire        o_emergency_message_valid,
  output wire        o_emergency_message_ext,
  output wire [28:0] o_emergency_message_can_id,
  output reg  [15:0] o_emergency_message_inhibit,
  output wire        o_emergency_message_inh_tick,
  output reg  [15:0] o_hb_period,
  output wire        o_hb_due
);
  localparam ST_IDLE = 2'b01;
  localparam ST_INIT = 2'b10;

  reg [1:0]  st_r;
  reg [31:0] rd_nxt;
  reg [31:0] ab_nxt;
  reg        wr_id;
  reg        wr_inh;
  reg        wr_hb;
  wire       hb_tick;

  // identity record is constant, selected by sub-index
  function [31:0] ident_word;
    input [7:0] sub;
    begin
      case (sub)
        `COE_SUB_COUNT:    ident_word = `COE_IDENT_COUNT;
        `COE_SUB_MAKER:    ident_word = MAKER_CODE;
        `COE_SUB_PRODUCT:  ident_word = PRODUCT;
        `COE_SUB_REVISION: ident_word = {REV_MAJOR, REV_MINOR};
        `COE_SUB_SERIAL:   ident_word = SERIAL;
        default:           ident_word = 32'h0000_0000;
      endcase
    end
  endfunction

  // decoded identifier fields for the transmit engine
  assign o_emergency_message_valid  = ~o_emergency_message_id[`COE_EMERGENCY_MESSAGE_INVALID_BIT];
  assign o_emergency_message_ext    = o_emergency_message_id[`COE_EMERGENCY_MESSAGE_EXT_BIT];
  assign o_emergency_message_can_id = o_emergency_message_ext ? o_emergency_message_id[28:0]
                       : {18'h00000, o_emergency_message_id[10:0]};

  // access decode: read data, abort code and write strobes
  always @*
  begin
    rd_nxt = 32'h0000_0000;
    ab_nxt = `COE_ABORT_NONE;
    wr_id  = 1'b0;
    wr_inh = 1'b0;
    wr_hb  = 1'b0;
    case (i_index)
      `COE_IDX_EMERGENCY_MESSAGE_ID:
      begin
        if (i_sub != 8'h00)
          ab_nxt = `COE_ABORT_NOSUB;
        else if (!i_wr)
          rd_nxt = o_emergency_message_id;
        else if (i_wdata[`COE_EMERGENCY_MESSAGE_EXT_BIT] && (EXT_SUPPORT == 0))
          ab_nxt = `COE_ABORT_VALUE;
        else if (i_wdata[`COE_EMERGENCY_MESSAGE_RSVD_BIT])
          ab_nxt = `COE_ABORT_VALUE;
        else if (!i_wdata[`COE_EMERGENCY_MESSAGE_EXT_BIT] && (i_wdata[28:11] != 18'h0))
          ab_nxt = `COE_ABORT_VALUE;
        else if (!o_emergency_message_id[`COE_EMERGENCY_MESSAGE_INVALID_BIT] &&
                 (i_wdata[29:0] != o_emergency_message_id[29:0]))
          ab_nxt = `COE_ABORT_VALUE;
        else
          wr_id = 1'b1;
      end
      `COE_IDX_EMERGENCY_MESSAGE_INH:
      begin
        if (i_sub != 8'h00)
          ab_nxt = `COE_ABORT_NOSUB;
        else if (!i_wr)
          rd_nxt = {16'h0000, o_emergency_message_inhibit};
        else
          wr_inh = 1'b1;
      end
      `COE_IDX_HB_PERIOD:
      begin
        if (i_sub != 8'h00)
          ab_nxt = `COE_ABORT_NOSUB;
        else if (!i_wr)
          rd_nxt = {16'h0000, o_hb_period};
        else
          wr_hb = 1'b1;
      end
      `COE_IDX_IDENTITY:
      begin
        if (i_sub > `COE_SUB_SERIAL)
          ab_nxt = `COE_ABORT_NOSUB;
        else if (i_wr)
          ab_nxt = `COE_ABORT_RDONLY;
        else
          rd_nxt = ident_word(i_sub);
      end
      default:
        ab_nxt = `COE_ABORT_NOOBJ;
    endcase
  end

  // registers and answer; one init cycle loads the node-based identifier
  // because the node number is a port and may not feed the reset value
  always @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      st_r           <= ST_INIT;
      o_emergency_message_id      <= `COE_EMERGENCY_MESSAGE_BASE;
      o_emergency_message_inhibit <= `COE_INH_RESET;
      o_hb_period    <= `COE_HB_RESET;
      o_ack          <= 1'b0;
      o_rdata        <= 32'h0000_0000;
      o_abort        <= `COE_ABORT_NONE;
    end
    else
    begin
      o_ack <= 1'b0;
      case (st_r)
        ST_INIT:
        begin
          o_emergency_message_id <= `COE_EMERGENCY_MESSAGE_BASE + {25'h0, i_node_id};
          st_r      <= ST_IDLE;
        end
        ST_IDLE:
        begin
          if (i_req)
          begin
            o_ack   <= 1'b1;
            o_rdata <= rd_nxt;
            o_abort <= ab_nxt;
            if (wr_id)
              o_emergency_message_id <= {i_wdata[31], 1'b0, i_wdata[29:0]};
            if (wr_inh)
              o_emergency_message_inhibit <= i_wdata[15:0];
            if (wr_hb)
              o_hb_period <= i_wdata[15:0];
          end
        end
        default:
          st_r <= ST_IDLE;
      endcase
    end
  end

  // 100 us tick for the emergency inhibit engine
  coe_tick #(.DIV(INH_CYC)) u_inh_tick (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .o_tick  (o_emergency_message_inh_tick)
  );

  // 1 ms tick feeding the heartbeat period timer
  coe_tick #(.DIV(HB_CYC)) u_hb_tick (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .o_tick  (hb_tick)
  );

  coe_period u_hb (
    .i_clk    (i_clk),
    .i_rst_b  (i_rst_b),
    .i_tick   (hb_tick),
    .i_period (o_hb_period),
    .o_fire   (o_hb_due)
  );
endmodule // coe_objects
`default_nettype wire

// ---- tb/coe_master.sv ----
// network master model: issues single dictionary accesses
// assumes the block answers one clock after the request edge
`timescale 1ns/1ps
`default_nettype none
module coe_master (
  input  wire logic        i_clk,
  input  wire logic        i_ack,
  input  wire logic [31:0] i_rdata,
  input  wire logic [31:0] i_abort,
  output var  logic        o_req,
  output var  logic        o_wr,
  output var  logic [15:0] o_index,
  output var  logic [7:0]  o_sub,
  output var  logic [31:0] o_wdata
);
  initial
  begin
    o_req = 1'b0;
    o_wr = 1'b0;
    o_index = 16'h0;
    o_sub = 8'h0;
    o_wdata = 32'h0;
  end

  // one-cycle request pulse, answer taken at the next falling edge
  task automatic xfer(input logic w, input logic [15:0] x,
    input logic [7:0] s, input logic [31:0] d,
    output logic ok, output logic [31:0] rd, output logic [31:0] ab);
    @(negedge i_clk);
    o_req = 1'b1;
    o_wr = w;
    o_index = x;
    o_sub = s;
    o_wdata = d;
    @(negedge i_clk);
    o_req = 1'b0;
    o_wdata = ~d;  // released data must not look stale
    ok = i_ack;
    rd = i_rdata;
    ab = i_abort;
  endtask
endmodule // coe_master
`default_nettype wire

// ---- tb/coe_objects_sva.sv ----
// checker on the dictionary object block ports
// assumes EXT_SUPPORT is 0 and no request at the init edge
`timescale 1ns/1ps
`default_nettype none
module coe_objects_sva (
  input wire logic        i_clk,
  input wire logic        i_rst_b,
  input wire logic        i_req,
  input wire logic        i_wr,
  input wire logic [15:0] i_index,
  input wire logic [7:0]  i_sub,
  input wire logic [31:0] i_wdata,
  input wire logic        o_ack,
  input wire logic [31:0] o_rdata,
  input wire logic [31:0] o_abort,
  input wire logic [31:0] o_emergency_message_id,
  input wire logic        o_emergency_message_valid,
  input wire logic [28:0] o_emergency_message_can_id,
  input wire logic [15:0] o_hb_period,
  input wire logic        o_hb_due
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // writes to the identifier word, the only object with locked bits
  wire emw = i_req && i_wr && i_index == 16'h1014 && i_sub == 8'h0;

  AST_ACK:
    assert property (o_ack == $past(i_req)) else $error("ack timing");
  AST_VALID:
    assert property (o_emergency_message_valid == !o_emergency_message_id[31]) else $error("valid");
  AST_RSVD:
    assert property (!o_emergency_message_id[30] && !o_emergency_message_id[29]) else $error("rsvd");
  AST_STD:
    assert property (o_emergency_message_id[28:11] == 18'h0 &&
      o_emergency_message_can_id == {18'h0, o_emergency_message_id[10:0]}) else $error("std id");
  AST_EXTW:
    assert property (emw && i_wdata[29] |=> o_abort == 32'h0609_0030)
      else $error("ext write taken");
  AST_LOCK:
    assert property (emw && !o_emergency_message_id[31] &&
      i_wdata[29:0] != o_emergency_message_id[29:0] |=> o_abort == 32'h0609_0030
      && $stable(o_emergency_message_id)) else $error("locked id changed");
  AST_HB0:
    assert property ((o_hb_period == 16'h0) [*2] |-> !o_hb_due)
      else $error("heartbeat while off");
  AST_CNT:
    assert property (i_req && !i_wr && i_index == 16'h1018 && i_sub == 8'h0
      |=> o_rdata == 32'h4 && o_abort == 32'h0) else $error("count");
  AST_IDRO:
    assert property (i_req && i_wr && i_index == 16'h1018 && i_sub <= 8'h4
      |=> o_ack && o_abort == 32'h0601_0002) else $error("ro write");
endmodule // coe_objects_sva
bind coe_objects coe_objects_sva coe_objects_sva_i (.i_clk(i_clk),
  .i_rst_b(i_rst_b), .i_req(i_req), .i_wr(i_wr), .i_index(i_index),
  .i_sub(i_sub), .i_wdata(i_wdata), .o_ack(o_ack), .o_rdata(o_rdata),
  .o_abort(o_abort), .o_emergency_message_id(o_emergency_message_id), .o_emergency_message_valid(o_emergency_message_valid),
  .o_emergency_message_can_id(o_emergency_message_can_id), .o_hb_period(o_hb_period),
  .o_hb_due(o_hb_due));
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench for the dictionary object block
// assumes short unit timers: 4 cycles per 100 us, 10 per ms
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk, rst_b, req, wr, ack, ev, ext, hb_due, tick, ok;
  logic [6:0]  node;
  logic [15:0] idx, inh, hb;
  logic [7:0]  sub;
  logic [31:0] wd, rd, ab, eid, r, a;
  logic [28:0] cid;
  int          error_cnt, checked, cyc, n;
  logic [31:0] idv [5] = '{32'h4, 32'h1357_9bdf, 32'h2468_ace0,
                           32'h0003_0001, 32'h0000_0001}; // arbitrary
  logic [31:0] wv [7] = '{32'h123, 32'h8000_0085, 32'ha000_0085,
    32'hc000_0085, 32'h8000_0885, 32'h8000_0123, 32'h123};
  logic [31:0] av [7] = '{32'h0609_0030, 0, 32'h0609_0030, 32'h0609_0030,
    32'h0609_0030, 0, 0};
  logic [31:0] iv [7] = '{32'h85, 32'h8000_0085, 32'h8000_0085,
    32'h8000_0085, 32'h8000_0085, 32'h8000_0123, 32'h123};

  // minor revision and serial keep their default of 1, still distinct
  coe_objects #(.MAKER_CODE(32'h1357_9bdf), .PRODUCT(32'h2468_ace0),
    .REV_MAJOR(16'h0003), .INH_CYC(4), .HB_CYC(10)) coe_objects_i (
    .i_clk(clk), .i_rst_b(rst_b),
    .i_node_id(node), .i_req(req), .i_wr(wr), .i_index(idx), .i_sub(sub),
    .i_wdata(wd), .o_ack(ack), .o_rdata(rd), .o_abort(ab), .o_emergency_message_id(eid),
    .o_emergency_message_valid(ev), .o_emergency_message_ext(ext), .o_emergency_message_can_id(cid),
    .o_emergency_message_inhibit(inh), .o_emergency_message_inh_tick(tick), .o_hb_period(hb),
    .o_hb_due(hb_due));
  coe_master coe_master_i (.i_clk(clk), .i_ack(ack), .i_rdata(rd),
    .i_abort(ab), .o_req(req), .o_wr(wr), .o_index(idx), .o_sub(sub),
    .o_wdata(wd));

  initial clk = 1'b0;
  always #10 clk = ~clk;
  // hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      error_cnt++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      error_cnt++;
      $display("wrong value at %0t: saw %h want %h", $time, s, e);
    end
  endtask

  task automatic acc(input logic w, input logic [15:0] x,
    input logic [7:0] s, input logic [31:0] d);
    coe_master_i.xfer(w, x, s, d, ok, r, a);
    chk(ok, 1);
  endtask

  // cycles from one pulse to the next, bounded
  task automatic gap(input bit h, output int g);
    g = 0;
    do @(negedge clk); while (!(h ? hb_due : tick) && ++g < 100);
    g = 0;
    do begin @(negedge clk); g++; end while (!(h ? hb_due : tick) && g < 100);
  endtask

  task automatic t_ident;
    for (int i = 0; i < 5; i++)
    begin
      acc(0, 16'h1018, i, 0);
      chk(r, idv[i]);
      acc(1, 16'h1018, i, 32'hffff_ffff);
      chk(a, 32'h0601_0002);
      acc(0, 16'h1018, i, 0);
      chk(r, idv[i]);
    end
  endtask

  task automatic t_emergency_message;
    for (int i = 0; i < 7; i++)
    begin
      acc(1, 16'h1014, 0, wv[i]);
      chk(a, av[i]);
      chk(eid, iv[i]);
    end
    chk(cid, 32'h123);
    chk(ev, 1);
    chk(ext, 0);
    acc(0, 16'h1014, 0, 0);
    chk(r, 32'h123);
    chk(a, 0);
  endtask

  task automatic t_timer;
    acc(1, 16'h1015, 0, 32'h1_0003);
    chk(inh, 3);
    acc(0, 16'h1015, 0, 0);
    chk(r, 3);
    gap(0, n);
    chk(n, 4);
    acc(1, 16'h1017, 0, 2);
    chk(hb, 2);
    acc(0, 16'h1017, 0, 0);
    chk(r, 2);
    acc(1, 16'h1017, 8'h01, 5);
    chk(a, 32'h0609_0011);
    chk(hb, 2);
    gap(1, n);
    chk(n, 20);
    acc(1, 16'h1017, 0, 0);
    n = 0;
    repeat (60) @(negedge clk) n += hb_due;
    chk(n, 0);
  endtask

  // second reset in mid-run, with another node number on the pins
  task automatic t_reset;
    @(negedge clk);
    rst_b = 1'b0;
    node = 7'h7f;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    repeat (2) @(negedge clk);
    chk(eid, 32'hff);
    chk({inh, hb}, 0);
    acc(0, 16'h1014, 0, 0);
    chk(r, 32'hff);
  endtask

  task automatic end_of_test;
    if (error_cnt == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    {rst_b, error_cnt, checked, cyc} = 0;
    node = 7'h05;
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    repeat (2) @(negedge clk);
    chk(eid, 32'h85);
    chk({inh, hb}, 0);
    t_ident();
    acc(0, 16'h1018, 8'h05, 0);
    chk(a, 32'h0609_0011);
    acc(0, 16'h1016, 0, 0);
    chk(a, 32'h0602_0000);
    t_emergency_message();
    t_timer();
    t_reset();
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
